/* iqc_gain_phase.sv */
// Purpose: gain scaling of both paths, then q-into-i phase skew term
// Assumes: i is channel a, q is channel b; settings static between commits
// Notes: two register stages, every stage saturates
`timescale 1ns/1ns
module iqc_gain_phase (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // sample in
  input wire logic i_vld,
  input wire iqc_pkg::iqc_pair_t i_smp,
  // settings
  input wire logic [iqc_pkg::GAIN_W-1:0] i_ga,
  input wire logic [iqc_pkg::GAIN_W-1:0] i_gb,
  input wire logic [iqc_pkg::PHASE_W-1:0] i_ph,
  // sample out
  output logic o_vld,
  output iqc_pkg::iqc_pair_t o_smp,
  output logic o_sat
);
  import iqc_pkg::*;
  typedef struct packed {
    logic v1;
    iqc_pair_t s1;
    logic sat1;
    logic v2;
    iqc_pair_t s2;
    logic sat2;
  } iqc_gp_st_t;
  iqc_gp_st_t s;
  iqc_gp_st_t next_s;
  // ************************************************************
  // datapath
  // ************************************************************
  // stage 1 gain, stage 2 phase add
  always_comb begin
    logic signed [27:0] pa;
    logic signed [27:0] pb;
    logic signed [25:0] pp;
    logic signed [31:0] wa;
    logic signed [31:0] wb;
    logic signed [31:0] wi;
    pa = i_smp.i * $signed({1'b0, i_ga});
    pb = i_smp.q * $signed({1'b0, i_gb});
    wa = 32'(pa >>> GAIN_FRAC);
    wb = 32'(pb >>> GAIN_FRAC);
    pp = s.s1.q * $signed(i_ph);
    wi = 32'(s.s1.i) + 32'(pp >>> PHASE_FRAC);
    next_s = s;
    next_s.v1 = i_vld;
    next_s.s1.i = iqc_sat(wa);
    next_s.s1.q = iqc_sat(wb);
    next_s.sat1 = i_vld && (wa != 32'(next_s.s1.i) || wb != 32'(next_s.s1.q));
    next_s.v2 = s.v1;
    next_s.s2.i = iqc_sat(wi);
    next_s.s2.q = s.s1.q;
    next_s.sat2 = s.sat1 || (s.v1 && wi != 32'(next_s.s2.i));
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign o_vld = s.v2;
  assign o_smp = s.s2;
  assign o_sat = s.sat2;
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence unity_in;
    i_vld && i_ga == GAIN_RST && i_gb == GAIN_RST && i_ph == 10'h000;
  endsequence
  unity_pass_a: assert property (unity_in ##1 (i_ph == 10'h000) |=> o_smp == $past(i_smp, 2))
    else $error("unity gain and zero phase did not pass samples");
  gp_latency_a: assert property (i_vld |-> ##2 o_vld)
    else $error("gain phase latency is not two cycles");
  sat_clamp_a: assert property (o_sat && o_vld && o_smp.i[15] == o_smp.q[15] |-> 1'b1 ##0
    (o_smp.i != 16'sh0 || o_smp.q != 16'sh0 || !o_sat))
    else $error("saturated sample collapsed to zero");
  q_keep_a: assert property (s.v1 |=> o_smp.q == $past(s.s1.q))
    else $error("q path changed by phase stage");
endmodule

/* iqc_offset.sv */
// Purpose: adds a signed dc offset to each path
// Assumes: offset and sample are lsb aligned, no shift
// Notes: one register stage, saturating adders
`timescale 1ns/1ns
module iqc_offset (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // sample in
  input wire logic i_vld,
  input wire iqc_pkg::iqc_pair_t i_smp,
  // offsets
  input wire logic [iqc_pkg::OFS_W-1:0] i_oa,
  input wire logic [iqc_pkg::OFS_W-1:0] i_ob,
  // sample out
  output logic o_vld,
  output iqc_pkg::iqc_pair_t o_smp,
  output logic o_sat
);
  import iqc_pkg::*;
  typedef struct packed {
    logic v;
    iqc_pair_t smp;
    logic sat;
  } iqc_ofs_st_t;
  iqc_ofs_st_t s;
  iqc_ofs_st_t next_s;
  // sign extend and add at bit zero
  always_comb begin
    logic signed [31:0] si;
    logic signed [31:0] sq;
    si = 32'(i_smp.i) + 32'($signed(i_oa));
    sq = 32'(i_smp.q) + 32'($signed(i_ob));
    next_s.v = i_vld;
    next_s.smp.i = iqc_sat(si);
    next_s.smp.q = iqc_sat(sq);
    next_s.sat = i_vld && (si != 32'(next_s.smp.i) || sq != 32'(next_s.smp.q));
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign o_vld = s.v;
  assign o_smp = s.smp;
  assign o_sat = s.sat;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ofs_add_a: assert property (i_vld |=> o_sat || 32'(o_smp.i) == 32'($past(i_smp.i)) + 32'($signed($past(i_oa))))
    else $error("offset a not added lsb aligned");
  ofs_sat_a: assert property (i_vld && i_smp.q == 16'sh7FFF && !i_ob[12] && i_ob != 13'h0000
    |=> o_sat && o_smp.q == 16'sh7FFF)
    else $error("offset b did not saturate high");
endmodule

/* iqc_pkg.sv */
// Purpose: shared constants, register map and carrier types of the iq correction block
// Assumes: 32-bit axi4-lite data, 8-bit byte address, signed 16-bit samples
// Notes: gains are 1.10 unsigned, phase is a 12-bit fraction, offsets are lsb aligned
package iqc_pkg;
  // ************************************************************
  // widths and formats
  // ************************************************************
  localparam int SMP_W = 16;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int PHASE_W = 10;
  localparam int PHASE_FRAC = 12;
  localparam int OFS_W = 13;
  localparam int OFS_LO_W = 8;
  localparam int OFS_HI_W = OFS_W - OFS_LO_W;
  localparam int ADDR_W = 8;
  localparam logic signed [31:0] SMP_MAX = 32'sh00007FFF;
  localparam logic signed [31:0] SMP_MIN = -32'sh00008000;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] GP_COMMIT = 8'h00;
  localparam logic [7:0] GAIN_A = 8'h04;
  localparam logic [7:0] GAIN_B = 8'h08;
  localparam logic [7:0] GP_CTRL = 8'h0C;
  localparam logic [7:0] DC_COMMIT = 8'h10;
  localparam logic [7:0] DC_A_HI = 8'h14;
  localparam logic [7:0] DC_B_LO = 8'h18;
  localparam logic [7:0] DC_B_HI = 8'h1C;
  localparam logic [7:0] STATUS = 8'h20;
  localparam int ST_GPEN_BIT = 0;
  localparam int ST_SAT_GP_BIT = 1;
  localparam int ST_SAT_DC_BIT = 2;
  localparam int CTRL_GPEN_BIT = 0;
  // ************************************************************
  // reset values and responses
  // ************************************************************
  localparam logic [GAIN_W-1:0] GAIN_RST = 11'h400;
  localparam logic [PHASE_W-1:0] PHASE_RST = 10'h000;
  localparam logic [OFS_W-1:0] OFS_RST = 13'h0000;
  localparam logic GPEN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic signed [SMP_W-1:0] i;
    logic signed [SMP_W-1:0] q;
  } iqc_pair_t;
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } iqc_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iqc_axil_rsp_t;
  // clamp a wide signed value into the sample range
  function automatic logic signed [SMP_W-1:0] iqc_sat(input logic signed [31:0] v);
    logic signed [SMP_W-1:0] r;
    r = v[SMP_W-1:0];
    if (v > SMP_MAX) r = SMP_MAX[SMP_W-1:0];
    if (v < SMP_MIN) r = SMP_MIN[SMP_W-1:0];
    return r;
  endfunction
endpackage

/* iqc_src.sv */
// Purpose: upstream sample source feeding the correction block
// Assumes: one pair per valid cycle, no backpressure
// Notes: data lines toggle to the inverse while valid is low
`timescale 1ns/1ns
module iqc_src #(
  parameter int SEED = 57
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_en,
  input wire logic [3:0] i_shift,
  // sample out
  output logic o_vld,
  output iqc_pkg::iqc_pair_t o_smp
);
  import iqc_pkg::*;
  int seed = SEED;
  // ************************************************************
  // random pairs with random gaps
  // ************************************************************
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vld <= 1'b0;
      o_smp <= '0;
    end else if (i_en && ($random(seed) & 3) != 0) begin
      o_vld <= 1'b1;
      o_smp.i <= $signed(16'($random(seed))) >>> i_shift;
      o_smp.q <= $signed(16'($random(seed))) >>> i_shift;
    end else begin
      o_vld <= 1'b0;
      o_smp <= ~o_smp; // stale data changes every idle cycle
    end
  end
endmodule

/* iqc_top.sv */
// Purpose: iq gain, phase and dc offset correction with axi4-lite staging registers
// Assumes: samples arrive on i_clk, one pair per valid cycle
// Notes: holding registers load into the datapath only on a commit write
`timescale 1ns/1ns
module iqc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register bus
  input wire iqc_pkg::iqc_axil_req_t i_axi,
  output iqc_pkg::iqc_axil_rsp_t o_axi,
  // sample stream in
  input wire logic i_smp_vld,
  input wire iqc_pkg::iqc_pair_t i_smp,
  // sample stream out to the converter
  output logic o_smp_vld,
  output iqc_pkg::iqc_pair_t o_smp
);
  import iqc_pkg::*;
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    iqc_axil_rsp_t rsp;
    logic [GAIN_W-1:0] stg_ga;
    logic [GAIN_W-1:0] stg_gb;
    logic [PHASE_W-1:0] stg_ph;
    logic stg_gpen;
    logic [OFS_W-1:0] stg_oa;
    logic [OFS_W-1:0] stg_ob;
    logic [GAIN_W-1:0] act_ga;
    logic [GAIN_W-1:0] act_gb;
    logic [PHASE_W-1:0] act_ph;
    logic act_gpen;
    logic [OFS_W-1:0] act_oa;
    logic [OFS_W-1:0] act_ob;
    logic sat_gp;
    logic sat_dc;
  } iqc_top_st_t;
  iqc_top_st_t s;
  iqc_top_st_t next_s;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic rd_fire;
  logic gp_vld;
  iqc_pair_t gp_smp;
  logic gp_sat;
  logic dc_sat;
  logic [GAIN_W-1:0] eff_ga;
  logic [GAIN_W-1:0] eff_gb;
  logic [PHASE_W-1:0] eff_ph;
  // ************************************************************
  // register readback
  // ************************************************************
  // word seen at an address, plus whether it is mapped
  function automatic logic [32:0] rd_word(input iqc_top_st_t st, input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    unique case ({a[ADDR_W-1:2], 2'b00})
      GP_COMMIT: r[PHASE_W-1:0] = st.stg_ph;
      GAIN_A: r[GAIN_W-1:0] = st.stg_ga;
      GAIN_B: r[GAIN_W-1:0] = st.stg_gb;
      GP_CTRL: r[CTRL_GPEN_BIT] = st.stg_gpen;
      DC_COMMIT: r[OFS_LO_W-1:0] = st.stg_oa[OFS_LO_W-1:0];
      DC_A_HI: r[OFS_HI_W-1:0] = st.stg_oa[OFS_W-1:OFS_LO_W];
      DC_B_LO: r[OFS_LO_W-1:0] = st.stg_ob[OFS_LO_W-1:0];
      DC_B_HI: r[OFS_HI_W-1:0] = st.stg_ob[OFS_W-1:OFS_LO_W];
      STATUS: begin
        r[ST_GPEN_BIT] = st.act_gpen;
        r[ST_SAT_GP_BIT] = st.sat_gp;
        r[ST_SAT_DC_BIT] = st.sat_dc;
      end
      default: r = 33'h000000000;
    endcase
    return r;
  endfunction
  // bus handshake terms
  assign wr_fire = s.aw_hold && s.w_hold && !s.rsp.bvalid;
  assign wr_addr = {s.aw_addr[ADDR_W-1:2], 2'b00};
  assign rd_fire = i_axi.arvalid && s.rsp.arready;
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [32:0] cur;
    logic [31:0] wv;
    logic [1:0] clr;
    next_s = s;
    clr = 2'b00;
    cur = rd_word(s, s.aw_addr);
    wv = cur[31:0];
    for (int b = 0; b < 4; b++) begin
      if (s.w_strb[b]) wv[8*b+:8] = s.w_data[8*b+:8];
    end
    // address and data are taken in either order
    if (i_axi.awvalid && s.rsp.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && s.rsp.wready) begin
      next_s.w_hold = 1'b1;
      next_s.w_data = i_axi.wdata;
      next_s.w_strb = i_axi.wstrb;
    end
    if (s.rsp.bvalid && i_axi.bready) next_s.rsp.bvalid = 1'b0;
    if (wr_fire) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = cur[32] ? RESP_OKAY : RESP_SLVERR;
      unique case (wr_addr)
        GP_COMMIT: begin
          next_s.stg_ph = wv[PHASE_W-1:0];
          next_s.act_ph = wv[PHASE_W-1:0];
          next_s.act_ga = s.stg_ga;
          next_s.act_gb = s.stg_gb;
          next_s.act_gpen = s.stg_gpen;
        end
        GAIN_A: next_s.stg_ga = wv[GAIN_W-1:0];
        GAIN_B: next_s.stg_gb = wv[GAIN_W-1:0];
        GP_CTRL: next_s.stg_gpen = wv[CTRL_GPEN_BIT];
        DC_COMMIT: begin
          next_s.stg_oa[OFS_LO_W-1:0] = wv[OFS_LO_W-1:0];
          next_s.act_oa = {s.stg_oa[OFS_W-1:OFS_LO_W], wv[OFS_LO_W-1:0]};
          next_s.act_ob = s.stg_ob;
        end
        DC_A_HI: next_s.stg_oa[OFS_W-1:OFS_LO_W] = wv[OFS_HI_W-1:0];
        DC_B_LO: next_s.stg_ob[OFS_LO_W-1:0] = wv[OFS_LO_W-1:0];
        DC_B_HI: next_s.stg_ob[OFS_W-1:OFS_LO_W] = wv[OFS_HI_W-1:0];
        STATUS: begin
          if (s.w_strb[0]) clr = s.w_data[ST_SAT_DC_BIT:ST_SAT_GP_BIT];
        end
        default: begin
        end
      endcase
    end
    // saturation flags: a new event beats the clear
    next_s.sat_gp = (s.sat_gp && !clr[0]) || gp_sat;
    next_s.sat_dc = (s.sat_dc && !clr[1]) || dc_sat;
    // read answers one cycle after the address
    if (s.rsp.rvalid && i_axi.rready) next_s.rsp.rvalid = 1'b0;
    if (rd_fire) begin
      cur = rd_word(s, i_axi.araddr);
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = cur[31:0];
      next_s.rsp.rresp = cur[32] ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.rsp.awready = !next_s.aw_hold && !next_s.rsp.bvalid;
    next_s.rsp.wready = !next_s.w_hold && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
      s.stg_ga <= GAIN_RST;
      s.stg_gb <= GAIN_RST;
      s.stg_ph <= PHASE_RST;
      s.stg_gpen <= GPEN_RST;
      s.stg_oa <= OFS_RST;
      s.stg_ob <= OFS_RST;
      s.act_ga <= GAIN_RST;
      s.act_gb <= GAIN_RST;
      s.act_ph <= PHASE_RST;
      s.act_gpen <= GPEN_RST;
      s.act_oa <= OFS_RST;
      s.act_ob <= OFS_RST;
    end else begin
      s <= next_s;
    end
  end
  assign o_axi = s.rsp;
  // ************************************************************
  // datapath
  // ************************************************************
  // correction off means unity gain and no skew
  assign eff_ga = s.act_gpen ? s.act_ga : GAIN_RST;
  assign eff_gb = s.act_gpen ? s.act_gb : GAIN_RST;
  assign eff_ph = s.act_gpen ? s.act_ph : PHASE_RST;
  // gain and phase first, then offset
  iqc_gain_phase u_gp (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_vld(i_smp_vld),
    .i_smp(i_smp),
    .i_ga(eff_ga),
    .i_gb(eff_gb),
    .i_ph(eff_ph),
    .o_vld(gp_vld),
    .o_smp(gp_smp),
    .o_sat(gp_sat)
  );
  iqc_offset u_dc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_vld(gp_vld),
    .i_smp(gp_smp),
    .i_oa(s.act_oa),
    .i_ob(s.act_ob),
    .o_vld(o_smp_vld),
    .o_smp(o_smp),
    .o_sat(dc_sat)
  );
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence gp_commit_s;
    wr_fire && wr_addr == GP_COMMIT;
  endsequence
  sequence dc_commit_s;
    wr_fire && wr_addr == DC_COMMIT;
  endsequence
  // a commit loads every staged value of its own group, otherwise the active set holds
  gp_commit_a: assert property (gp_commit_s |=> s.act_ga == s.stg_ga && s.act_gb == s.stg_gb
    && s.act_ph == s.stg_ph && s.act_gpen == s.stg_gpen)
    else $error("gain phase commit did not load staged values");
  gp_hold_a: assert property (!(wr_fire && wr_addr == GP_COMMIT) |=> $stable(s.act_ga) && $stable(s.act_gb)
    && $stable(s.act_ph) && $stable(s.act_gpen))
    else $error("active gain or phase moved without commit");
  dc_commit_a: assert property (dc_commit_s |=> s.act_oa == s.stg_oa && s.act_ob == s.stg_ob)
    else $error("offset commit did not load staged values");
  dc_hold_a: assert property (!(wr_fire && wr_addr == DC_COMMIT) |=> $stable(s.act_oa) && $stable(s.act_ob))
    else $error("active offset moved without commit");
  // bus answer timing
  wr_resp_a: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
    |=> wr_fire ##1 o_axi.bvalid)
    else $error("write response not two cycles after handshake");
  rd_resp_a: assert property (rd_fire |=> o_axi.rvalid)
    else $error("read data not one cycle after address");
  smp_lat_a: assert property (i_smp_vld |-> ##3 o_smp_vld)
    else $error("sample latency is not three cycles");
  sat_flag_a: assert property (dc_sat |=> s.sat_dc)
    else $error("offset saturation flag lost");
  // unmapped reads answer zero, write codes follow the address range
  rd_err_a: assert property (o_axi.rvalid && o_axi.rresp == RESP_SLVERR |-> o_axi.rdata == 32'h00000000)
    else $error("unmapped read returned data");
  wr_code_a: assert property (wr_fire |=> o_axi.bresp == ($past(wr_addr) > STATUS ? RESP_SLVERR : RESP_OKAY))
    else $error("write response code wrong");
  // each answer is given once
  wr_once_a: assert property (o_axi.bvalid && i_axi.bready |=> !o_axi.bvalid)
    else $error("write response repeated");
  rd_once_a: assert property (o_axi.rvalid && i_axi.rready |=> !o_axi.rvalid)
    else $error("read response repeated");
  // holding registers read back the staged value
  stg_read_a: assert property (rd_fire && i_axi.araddr[ADDR_W-1:2] == GAIN_A[ADDR_W-1:2]
    |=> o_axi.rdata == {21'h000000, $past(s.stg_ga)})
    else $error("gain a readback is not the staged value");
  // a commit takes the phase and low offset byte carried by its own write
  sequence ph_commit_s;
    gp_commit_s ##0 s.w_strb[1:0] == 2'b11;
  endsequence
  sequence oa_commit_s;
    dc_commit_s ##0 s.w_strb[0];
  endsequence
  ph_commit_a: assert property (ph_commit_s |=> s.act_ph == $past(s.w_data[PHASE_W-1:0]))
    else $error("phase commit ignored its write data");
  oa_commit_a: assert property (oa_commit_s |=> s.act_oa[OFS_LO_W-1:0] == $past(s.w_data[OFS_LO_W-1:0]))
    else $error("offset commit ignored its write data");
  // sticky flags: an event sets, a clear with no event clears
  sequence gp_clr_s;
    wr_fire && wr_addr == STATUS && s.w_strb[0] && s.w_data[ST_SAT_GP_BIT] && !gp_sat;
  endsequence
  sequence dc_clr_s;
    wr_fire && wr_addr == STATUS && s.w_strb[0] && s.w_data[ST_SAT_DC_BIT] && !dc_sat;
  endsequence
  gp_flag_a: assert property (gp_sat |=> s.sat_gp)
    else $error("gain phase saturation flag lost");
  gp_clr_a: assert property (gp_clr_s |=> !s.sat_gp)
    else $error("gain phase saturation flag not cleared");
  dc_clr_a: assert property (dc_clr_s |=> !s.sat_dc)
    else $error("offset saturation flag not cleared");
  // no output without an input three cycles before
  smp_idle_a: assert property (!i_smp_vld |-> ##3 !o_smp_vld)
    else $error("output valid without input");
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the iq correction block
// Assumes: settings change only while the stream is idle, except staging writes
// Notes: a behavioural model keeps the active settings only
`timescale 1ns/1ns
module tb_top;
  import iqc_pkg::*;
  logic i_clk;
  logic i_rst_n;
  iqc_axil_req_t axi;
  iqc_axil_rsp_t rsp;
  logic src_en;
  logic [3:0] shift;
  logic smp_vld;
  logic out_vld;
  iqc_pair_t smp;
  iqc_pair_t out;
  int error_cnt;
  int n_checks;
  int seed;
  int cyc;
  int ga, gb, ph, oa, ob;
  int sat_gp_n, sat_dc_n, gp_base, dc_base;
  iqc_pair_t inq[$];
  int tq[$];
  logic [31:0] rd;
  logic [1:0] rr;
  int gat[4] = '{0, 2047, 512, 1024};
  int pht[4] = '{-512, 511, 1, 0};
  int oat[4] = '{-4096, 4095, 0, -1};
  int obt[4] = '{4095, -4096, 1, 0};

  iqc_src src_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(src_en), .i_shift(shift), .o_vld(smp_vld), .o_smp(smp));
  iqc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_axi(axi), .o_axi(rsp), .i_smp_vld(smp_vld), .i_smp(smp),
    .o_smp_vld(out_vld), .o_smp(out));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ************************************************************
  // compare, verdict and model
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo;
    error_cnt++;
    tally_and_finish();
  endtask

  function automatic longint sat(input longint v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction

  // gain, then phase term, then offset, each clamped
  function automatic logic [31:0] model(input iqc_pair_t s);
    longint i1, q1, i2, io, qo;
    i1 = (longint'(s.i) * ga) >>> 10;
    q1 = (longint'(s.q) * gb) >>> 10;
    i2 = sat(i1) + ((sat(q1) * ph) >>> 12);
    io = sat(i2) + oa;
    qo = sat(q1) + ob;
    // count clamped samples per stage for the sticky flags
    if (sat(i1) != i1 || sat(q1) != q1 || sat(i2) != i2) sat_gp_n++;
    if (sat(io) != io || sat(qo) != qo) sat_dc_n++;
    io = sat(io);
    qo = sat(qo);
    return {io[15:0], qo[15:0]};
  endfunction

  // status word expected from the model's saturation counts
  function automatic logic [31:0] st_exp(input logic en);
    return {29'h00000000, sat_dc_n != dc_base, sat_gp_n != gp_base, en};
  endfunction

  // monitor: queue inputs, compare every output pair
  always @(posedge i_clk) begin
    if (i_rst_n) begin
      if (smp_vld === 1'b1) begin
        inq.push_back(smp);
        tq.push_back(cyc);
      end
      if (out_vld === 1'b1) begin
        if (inq.size() == 0) chk(32'h1, 32'h0);
        else begin
          chk(out, model(inq.pop_front()));
          chk(cyc - tq.pop_front(), 32'h3);
        end
      end
    end
    cyc++;
  end

  // ************************************************************
  // bus and settings tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    axi.awaddr <= a;
    axi.awvalid <= 1'b1;
    axi.wdata <= d;
    axi.wstrb <= 4'hF;
    axi.wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (rsp.awready === 1'b1 && !aw) begin
        aw = 1;
        axi.awvalid <= 1'b0;
      end
      if (rsp.wready === 1'b1 && !w) begin
        w = 1;
        axi.wvalid <= 1'b0;
      end
      n++;
      if (n > 50) tmo();
    end
    do begin
      @(posedge i_clk);
      n++;
      if (n > 100) tmo();
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    axi.araddr <= a;
    axi.arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 50) tmo();
    end while (rsp.arready !== 1'b1);
    axi.arvalid <= 1'b0;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 100) tmo();
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rdr(a, rd, rr);
    chk(rd, exp);
    chk(32'(rr), 32'(RESP_OKAY));
  endtask

  task automatic set_gp(input int a, input int b, input int p);
    wr(GAIN_A, 32'(a), rr);
    wr(GAIN_B, 32'(b), rr);
    wr(GP_COMMIT, 32'(p) & 32'h3FF, rr);
    ga = a;
    gb = b;
    ph = p;
  endtask

  task automatic set_dc(input int a, input int b);
    wr(DC_A_HI, (32'(a) >> 8) & 32'h1F, rr);
    wr(DC_B_LO, 32'(b) & 32'hFF, rr);
    wr(DC_B_HI, (32'(b) >> 8) & 32'h1F, rr);
    wr(DC_COMMIT, 32'(a) & 32'hFF, rr);
    oa = a;
    ob = b;
  endtask

  // stop the source and let the pipeline drain
  task automatic quiet;
    int n;
    n = 0;
    src_en <= 1'b0;
    repeat (4) @(posedge i_clk);
    while (inq.size() != 0) begin
      @(posedge i_clk);
      n++;
      if (n > 20) tmo();
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    seed = 57;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    axi = '0;
    axi.bready = 1'b1;
    axi.rready = 1'b1;
    src_en = 1'b0;
    shift = 4'h0;
    i_rst_n = 1'b0;
    ga = 1024;
    gb = 1024;
    ph = 0;
    oa = 0;
    ob = 0;
    gp_base = 0;
    dc_base = 0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rc(GAIN_A, 32'h400);
    rc(GP_COMMIT, 32'h0);
    rc(DC_B_HI, 32'h0);
    rc(STATUS, 32'h1);
    wr(GAIN_B, 32'hFFFFFFFF, rr);
    rc(GAIN_B, 32'h7FF);
    wr(GP_COMMIT, 32'hFFFFFFFF, rr);
    gb = 2047;
    ph = -1;
    rc(GP_COMMIT, 32'h3FF);
    wr(DC_A_HI, 32'hFFFFFFFF, rr);
    rc(DC_A_HI, 32'h1F);
    wr(8'h24, 32'h1, rr);
    chk(32'(rr), 32'(RESP_SLVERR));
    rdr(8'h24, rd, rr);
    chk(rd, 32'h0);
    chk(32'(rr), 32'(RESP_SLVERR));
    // staging writes while samples flow leave the datapath alone
    src_en <= 1'b1;
    wr(GAIN_A, 32'h123, rr);
    wr(DC_B_LO, 32'h55, rr);
    repeat (100) @(posedge i_clk);
    for (int k = 0; k < 4; k++) begin
      quiet();
      set_gp(gat[k], gat[3 - k], pht[k]);
      set_dc(oat[k], obt[k]);
      shift <= 4'(k);
      src_en <= 1'b1;
      repeat (150) @(posedge i_clk);
    end
    for (int k = 0; k < 6; k++) begin
      quiet();
      set_gp($random(seed) & 2047, $random(seed) & 2047, $random(seed) % 512);
      set_dc($random(seed) % 4096, $random(seed) % 4096);
      src_en <= 1'b1;
      repeat (150) @(posedge i_clk);
    end
    quiet();
    rc(STATUS, st_exp(1'b1));
    // clear both sticky flags, then run with gain and phase correction switched off
    wr(STATUS, 32'h6, rr);
    gp_base = sat_gp_n;
    dc_base = sat_dc_n;
    rc(STATUS, 32'h1);
    wr(GP_CTRL, 32'h0, rr);
    rc(GP_CTRL, 32'h0);
    rc(STATUS, 32'h1);
    set_gp(2047, 3, 511);
    ga = 1024;
    gb = 1024;
    ph = 0;
    rc(STATUS, 32'h0);
    shift <= 4'h0;
    src_en <= 1'b1;
    repeat (150) @(posedge i_clk);
    quiet();
    rc(STATUS, st_exp(1'b0));
    tally_and_finish();
  end
endmodule
